// ===== verilog/dcc_pkg.sv
// constants for the dual comparator control register bank
//
// Summary of operation
// - Bit 7 of each control register turns its comparator on when set and off when clear.
// - Bit 6 is a read-only result that reads 1 when the positive input is higher, or the complement if inverted.
// - Bit 5 set sends the comparator result to its output pin, clear keeps it internal.
// - Bit 4 set inverts the result before it reaches the result bit and the pin.
// - Bit 2 set takes the positive input from the internal reference, clear from the positive input pin.
// - Bits 1-0 choose which of four shared negative input pins feeds the negative input.
// - The pin is driven only when pin drive, enable and a cleared pin direction bit all hold together.
// - Any device reset returns both control registers to zero, switching both comparators off.
// - Each read or write of a control register captures the result into a change latch, and a change event
// fires on the edge where the result first differs from that latch.
package dcc_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [1:0] DCC_ADDR_CMP_ONE = 2'h0;
	localparam logic [1:0] DCC_ADDR_CMP_TWO = 2'h1;
	localparam int DCC_NUM_CMP = 2;
	localparam logic [7:0] DCC_CTRL_RESET = 8'h00;
	localparam logic [7:0] DCC_UNMAPPED_READ = 8'h00;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int DCC_BIT_ENABLE = 7;
	localparam int DCC_BIT_RESULT = 6;
	localparam int DCC_BIT_PIN_DRIVE = 5;
	localparam int DCC_BIT_INVERT = 4;
	localparam int DCC_BIT_UNUSED = 3;
	localparam int DCC_BIT_REF_SEL = 2;
	localparam int DCC_CH_MSB = 1;
	localparam int DCC_CH_LSB = 0;

	// bits that software may change; result and bit 3 are excluded
	localparam logic [7:0] DCC_WRITE_MASK = 8'hB7;

endpackage

// ===== verilog/dcc_cmp_chan.sv
// one comparator channel: input synchroniser, polarity, change latch and event edge
`timescale 1ns/100ps
module dcc_cmp_chan (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	input wire logic raw_in,
	input wire logic enable_in,
	input wire logic invert_in,
	input wire logic capture_in,
	output logic result_out,
	output logic change_out
);

	// ************************************************************
	// synchroniser and result
	// ************************************************************
	logic sync1_q;
	logic sync2_q;
	logic result_q;
	logic result_d;
	logic latch_q;
	logic latch_d;
	logic mism_q;
	logic mism_d;
	logic change_d;

	// a disabled comparator is taken as a low raw level
	assign result_d = (sync2_q & enable_in) ^ invert_in;
	// the capture samples the value software sees in the same read
	assign latch_d = capture_in ? result_q : latch_q;
	assign mism_d = result_q ^ latch_q;
	// edge, not level: one event per departure from the latch
	assign change_d = mism_d & ~mism_q & ~capture_in;

	// raw comparator output is asynchronous to the clock
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else if (clk_en_in) begin
			sync1_q <= raw_in;
			sync2_q <= sync1_q;
		end
	end

	// result, change latch and event pulse
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			result_q <= 1'b0;
			latch_q <= 1'b0;
			mism_q <= 1'b0;
			change_out <= 1'b0;
		end else if (clk_en_in) begin
			result_q <= result_d;
			latch_q <= latch_d;
			mism_q <= mism_d & ~capture_in;
			change_out <= change_d;
		end
	end

	assign result_out = result_q;

endmodule

// ===== verilog/dcc_regs.sv
// dual comparator control registers with result readback, pin control and change events
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module dcc_regs (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	input wire logic [1:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	input wire logic cmp_a_raw_in,
	input wire logic cmp_b_raw_in,
	input wire logic cmp_a_pin_direction_in,
	input wire logic cmp_b_pin_direction_in,
	output logic cmp_a_enable_out,
	output logic cmp_b_enable_out,
	output logic cmp_a_ref_sel_out,
	output logic cmp_b_ref_sel_out,
	output logic [1:0] cmp_a_neg_channel_out,
	output logic [1:0] cmp_b_neg_channel_out,
	output logic cmp_a_result_out,
	output logic cmp_b_result_out,
	output logic cmp_a_pin_out,
	output logic cmp_b_pin_out,
	output logic cmp_a_pin_oe_out,
	output logic cmp_b_pin_oe_out,
	output logic cmp_a_change_out,
	output logic cmp_b_change_out
);

	// ************************************************************
	// helper functions
	// ************************************************************

	// pin is driven only with all three conditions at once
	function automatic logic pin_drive_ok(input logic [7:0] ctrl, input logic dir);
		pin_drive_ok = ctrl[dcc_pkg::DCC_BIT_PIN_DRIVE] & ctrl[dcc_pkg::DCC_BIT_ENABLE] & ~dir;
	endfunction

	// address decode for one comparator register
	function automatic logic reg_hit(input logic [1:0] addr, input int idx);
		reg_hit = (idx == 0) ? (addr == dcc_pkg::DCC_ADDR_CMP_ONE) : (addr == dcc_pkg::DCC_ADDR_CMP_TWO);
	endfunction

	// ************************************************************
	// register state and decode
	// ************************************************************
	logic [7:0] ctrl_q [dcc_pkg::DCC_NUM_CMP];
	logic [7:0] ctrl_d [dcc_pkg::DCC_NUM_CMP];
	logic [dcc_pkg::DCC_NUM_CMP-1:0] hit;
	logic [dcc_pkg::DCC_NUM_CMP-1:0] wr_hit;
	logic [dcc_pkg::DCC_NUM_CMP-1:0] capture;
	logic [dcc_pkg::DCC_NUM_CMP-1:0] raw;
	logic [dcc_pkg::DCC_NUM_CMP-1:0] dir;
	logic [dcc_pkg::DCC_NUM_CMP-1:0] result;
	logic [dcc_pkg::DCC_NUM_CMP-1:0] change;
	logic [dcc_pkg::DCC_NUM_CMP-1:0] pin_q;
	logic [dcc_pkg::DCC_NUM_CMP-1:0] pin_oe_q;
	logic [7:0] view [dcc_pkg::DCC_NUM_CMP];
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;

	assign raw = {cmp_b_raw_in, cmp_a_raw_in};
	// direction bits come from the port logic on this clock
	assign dir = {cmp_b_pin_direction_in, cmp_a_pin_direction_in};

	// ************************************************************
	// per comparator decode and channel
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < dcc_pkg::DCC_NUM_CMP; gi++) begin : g_cmp
			assign hit[gi] = reg_hit(addr_in, gi);
			assign wr_hit[gi] = wr_in & hit[gi];
			// a write includes a read, so both capture the result
			assign capture[gi] = (rd_in | wr_in) & hit[gi];
			// result bit and bit 3 are kept out of the write path
			assign ctrl_d[gi] = wr_hit[gi] ? (wdata_in & dcc_pkg::DCC_WRITE_MASK) : ctrl_q[gi];
			// software view: stored fields plus live result, bit 3 zero
			assign view[gi] = {ctrl_q[gi][7], result[gi], ctrl_q[gi][5:4], 1'b0, ctrl_q[gi][2:0]};

			dcc_cmp_chan u_chan (
				.mclk_in(mclk_in),
				.reset_n_in(reset_n_in),
				.clk_en_in(clk_en_in),
				.raw_in(raw[gi]),
				.enable_in(ctrl_q[gi][dcc_pkg::DCC_BIT_ENABLE]),
				.invert_in(ctrl_q[gi][dcc_pkg::DCC_BIT_INVERT]),
				.capture_in(capture[gi]),
				.result_out(result[gi]),
				.change_out(change[gi])
			);

			// control register; reset turns the comparator off
			always_ff @(posedge mclk_in) begin
				if (!reset_n_in) begin
					ctrl_q[gi] <= dcc_pkg::DCC_CTRL_RESET;
				end else if (clk_en_in) begin
					ctrl_q[gi] <= ctrl_d[gi];
				end
			end

			// pin value and enable, registered so outputs come from flops
			always_ff @(posedge mclk_in) begin
				if (!reset_n_in) begin
					pin_q[gi] <= 1'b0;
					pin_oe_q[gi] <= 1'b0;
				end else if (clk_en_in) begin
					pin_q[gi] <= result[gi];
					pin_oe_q[gi] <= pin_drive_ok(ctrl_q[gi], dir[gi]);
				end
			end
		end
	endgenerate

	// ************************************************************
	// read data
	// ************************************************************

	// unmapped addresses read as zero; no side effect there
	assign rdata_d = !rd_in ? dcc_pkg::DCC_UNMAPPED_READ :
		hit[0] ? view[0] :
		hit[1] ? view[1] : dcc_pkg::DCC_UNMAPPED_READ;

	// data stand for exactly one cycle after the read strobe
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			rdata_q <= 8'h00;
		end else if (clk_en_in) begin
			rdata_q <= rdata_d;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign rdata_out = rdata_q;
	assign cmp_a_enable_out = ctrl_q[0][dcc_pkg::DCC_BIT_ENABLE];
	assign cmp_b_enable_out = ctrl_q[1][dcc_pkg::DCC_BIT_ENABLE];
	assign cmp_a_ref_sel_out = ctrl_q[0][dcc_pkg::DCC_BIT_REF_SEL];
	assign cmp_b_ref_sel_out = ctrl_q[1][dcc_pkg::DCC_BIT_REF_SEL];
	assign cmp_a_neg_channel_out = ctrl_q[0][dcc_pkg::DCC_CH_MSB:dcc_pkg::DCC_CH_LSB];
	assign cmp_b_neg_channel_out = ctrl_q[1][dcc_pkg::DCC_CH_MSB:dcc_pkg::DCC_CH_LSB];
	assign cmp_a_result_out = result[0];
	assign cmp_b_result_out = result[1];
	assign cmp_a_pin_out = pin_q[0];
	assign cmp_b_pin_out = pin_q[1];
	assign cmp_a_pin_oe_out = pin_oe_q[0];
	assign cmp_b_pin_oe_out = pin_oe_q[1];
	assign cmp_a_change_out = change[0];
	assign cmp_b_change_out = change[1];

	// ************************************************************
	// assertions
	// ************************************************************

	// enable bit follows a write to comparator one
	a_enable_write: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(clk_en_in && wr_in && addr_in == dcc_pkg::DCC_ADDR_CMP_ONE)
		|=> cmp_a_enable_out == $past(wdata_in[7]))
		else $error("enable bit did not follow write");

	// enable stays put while no write reaches comparator two
	a_enable_hold: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		!(wr_in && addr_in == dcc_pkg::DCC_ADDR_CMP_TWO) |=> $stable(cmp_b_enable_out))
		else $error("enable bit changed without a write");

	// read data bit 6 shows the result at the time of the read
	a_result_readback: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(clk_en_in && rd_in && addr_in == dcc_pkg::DCC_ADDR_CMP_ONE)
		|=> rdata_out[6] == $past(result[0]))
		else $error("result bit not read back");

	// pin value tracks the polarity adjusted result one cycle later
	a_pin_value: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		clk_en_in |=> cmp_a_pin_out == $past(cmp_a_result_out))
		else $error("pin value differs from result");

	// pin driven only with drive, enable and cleared direction
	a_pin_gating: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		clk_en_in |=> cmp_b_pin_oe_out == ($past(ctrl_q[1][5]) && $past(ctrl_q[1][7]) && !$past(dir[1])))
		else $error("pin enable gating wrong");

	// reference select follows a write
	a_ref_write: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(clk_en_in && wr_in && addr_in == dcc_pkg::DCC_ADDR_CMP_TWO)
		|=> cmp_b_ref_sel_out == $past(wdata_in[2]))
		else $error("reference select did not follow write");

	// channel field follows a write
	a_channel_write: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(clk_en_in && wr_in && addr_in == dcc_pkg::DCC_ADDR_CMP_ONE)
		|=> cmp_a_neg_channel_out == $past(wdata_in[1:0]))
		else $error("channel field did not follow write");

	// bit 3 never reads as one, even after writing it
	a_unused_zero: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(clk_en_in && rd_in) |=> rdata_out[3] == 1'b0)
		else $error("unimplemented bit read as one");

	// reset leaves both registers cleared
	a_reset_clears: assert property (@(posedge mclk_in)
		!reset_n_in |=> (ctrl_q[0] == 8'h00 && ctrl_q[1] == 8'h00 && !cmp_a_pin_oe_out && !cmp_b_pin_oe_out))
		else $error("reset did not clear control");

	// change event is a single cycle pulse
	a_change_pulse: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(clk_en_in && cmp_a_change_out) |=> !cmp_a_change_out)
		else $error("change event longer than one cycle");

	// no event in the cycle after a capture
	a_capture_quiet: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(clk_en_in && capture[1]) |=> !cmp_b_change_out)
		else $error("change event right after capture");

	// read data stand only in the cycle after a read
	a_read_single: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(clk_en_in && !rd_in) |=> rdata_out == 8'h00)
		else $error("read data without read strobe");

endmodule

// ===== tb/dcc_cmp_model.sv
// behavioural analog comparator core: input routing and raw decision
`timescale 1ns/100ps
module dcc_cmp_model (
	input wire logic clk_in,
	input wire logic enable_in,
	input wire logic ref_sel_in,
	input wire logic [1:0] neg_channel_in,
	input wire logic [3:0] pos_pin_in,
	input wire logic [3:0] internal_ref_in,
	input wire logic [15:0] neg_pins_in,
	output logic raw_out
);
	logic [3:0] pos_w;
	logic [3:0] neg_w;

	// ************************************************************
	// input routing
	// ************************************************************
	// positive side from reference or pin, negative from one of four shared pins
	assign pos_w = ref_sel_in ? internal_ref_in : pos_pin_in;
	assign neg_w = neg_pins_in[{neg_channel_in, 2'h0} +: 4];

	// an idle core has no valid level, so it wanders every cycle
	initial raw_out = 1'b0;
	always @(posedge clk_in) begin
		if (enable_in) begin
			raw_out <= (pos_w > neg_w);
		end else begin
			raw_out <= ~raw_out;
		end
	end
endmodule

// ===== tb/testbench.sv
// self-checking bench for the dual comparator control registers
`timescale 1ns/100ps
module testbench;
	logic mclk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0, rd = 1'b0, dir_a = 1'b1, dir_b = 1'b1, clk_en = 1'b1;
	logic [3:0] pos_a = 4'h0, pos_b = 4'h0, vref_a = 4'h0, vref_b = 4'h0;
	logic [15:0] negs = 16'h0000;
	logic [7:0] rdata, reg_a, reg_b, d;
	logic raw_a, raw_b, en_a, en_b, rs_a, rs_b, res_a, res_b, pin_a, pin_b, oe_a, oe_b, chg_a, chg_b;
	logic [1:0] ch_a, ch_b;
	integer n_mismatch = 0, comparisons = 0, seed = 32'h23DE, cyc = 0, n_chg = 0, base, i;

	// ************************************************************
	// clock, partners and design
	// ************************************************************
	always #5 mclk_in = ~mclk_in;
	dcc_cmp_model u_dcc_cmp_model_a (.clk_in(mclk_in), .enable_in(en_a), .ref_sel_in(rs_a), .neg_channel_in(ch_a),
		.pos_pin_in(pos_a), .internal_ref_in(vref_a), .neg_pins_in(negs), .raw_out(raw_a));
	dcc_cmp_model u_dcc_cmp_model_b (.clk_in(mclk_in), .enable_in(en_b), .ref_sel_in(rs_b), .neg_channel_in(ch_b),
		.pos_pin_in(pos_b), .internal_ref_in(vref_b), .neg_pins_in(negs), .raw_out(raw_b));
	dcc_regs u_dcc_regs (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .cmp_a_raw_in(raw_a), .cmp_b_raw_in(raw_b),
		.cmp_a_pin_direction_in(dir_a), .cmp_b_pin_direction_in(dir_b), .cmp_a_enable_out(en_a),
		.cmp_b_enable_out(en_b), .cmp_a_ref_sel_out(rs_a), .cmp_b_ref_sel_out(rs_b), .cmp_a_neg_channel_out(ch_a),
		.cmp_b_neg_channel_out(ch_b), .cmp_a_result_out(res_a), .cmp_b_result_out(res_b), .cmp_a_pin_out(pin_a),
		.cmp_b_pin_out(pin_b), .cmp_a_pin_oe_out(oe_a), .cmp_b_pin_oe_out(oe_b), .cmp_a_change_out(chg_a),
		.cmp_b_change_out(chg_b));

	task end_of_test;
		if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// cycle ceiling well above the ~1300 cycles the sequence needs; also counts change pulses,
	// comparator one in the low nibble and comparator two in the high one
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		n_chg <= n_chg + ((chg_a === 1'b1) ? 1 : 0) + ((chg_b === 1'b1) ? 16 : 0);
		if (cyc == 20000) begin
			n_mismatch = n_mismatch + 1;
			end_of_test;
		end
	end

	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task wr_reg(input logic [1:0] a, input logic [7:0] v);
		@(posedge mclk_in);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge mclk_in);
		wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, so sample mid-cycle
	task rd_reg(input logic [1:0] a, output logic [7:0] v);
		@(posedge mclk_in);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk_in);
		rd <= 1'b0;
		@(negedge mclk_in);
		v = rdata;
		@(posedge mclk_in);
	endtask

	function logic rawf(input logic [7:0] r, input logic [3:0] p, input logic [3:0] v);
		return (r[2] ? v : p) > negs[{r[1:0], 2'h0} +: 4];
	endfunction

	function logic resf(input logic [7:0] r, input logic raw);
		return (r[7] & raw) ^ r[4];
	endfunction

	// a disabled core reads as raw 0, so only the invert bit shows
	task check_all;
		logic xa;
		logic xb;
		repeat (8) @(posedge mclk_in);
		xa = resf(reg_a, rawf(reg_a, pos_a, vref_a));
		xb = resf(reg_b, rawf(reg_b, pos_b, vref_b));
		rd_reg(2'h0, d);
		chk(d, (reg_a & dcc_pkg::DCC_WRITE_MASK) | {1'b0, xa, 6'h00});
		rd_reg(2'h1, d);
		chk(d, (reg_b & dcc_pkg::DCC_WRITE_MASK) | {1'b0, xb, 6'h00});
		chk({en_a, rs_a, ch_a, res_a, pin_a, oe_a, 1'b0},
			{reg_a[7], reg_a[2], reg_a[1:0], xa, xa, reg_a[5] & reg_a[7] & ~dir_a, 1'b0});
		chk({en_b, rs_b, ch_b, res_b, pin_b, oe_b, 1'b0},
			{reg_b[7], reg_b[2], reg_b[1:0], xb, xb, reg_b[5] & reg_b[7] & ~dir_b, 1'b0});
	endtask

	task rand_cfg;
		reg_a = $random(seed);
		reg_b = $random(seed);
		pos_a <= $random(seed);
		pos_b <= $random(seed);
		vref_a <= $random(seed);
		vref_b <= $random(seed);
		negs <= $random(seed);
		{dir_a, dir_b} <= $random(seed);
		wr_reg(2'h0, reg_a);
		wr_reg(2'h1, reg_b);
	endtask

	// main sequence: reset, corners, random, unmapped, change events, mid-run reset
	initial begin
		reg_a = 8'h00;
		reg_b = 8'h00;
		repeat (6) @(posedge mclk_in);
		reset_n_in <= 1'b1;
		check_all;
		for (i = 0; i < 4; i++) begin
			reg_a = 8'hFC | i[1:0];
			reg_b = 8'h5C | {i[0], 5'h00, i[1:0]};
			dir_a <= i[0];
			dir_b <= ~i[0];
			negs <= 16'h1357;
			wr_reg(2'h0, reg_a);
			wr_reg(2'h1, reg_b);
			check_all;
		end
		for (i = 0; i < 60; i++) begin
			rand_cfg;
			check_all;
		end
		wr_reg(2'h2, 8'hFF);
		wr_reg(2'h3, 8'hFF);
		rd_reg(2'h3, d);
		chk(d, dcc_pkg::DCC_UNMAPPED_READ);
		check_all;
		// frozen clock enable: a write must not land, so the old contents still read back
		clk_en <= 1'b0;
		wr_reg(2'h0, ~reg_a);
		clk_en <= 1'b1;
		check_all;
		// rising result pulses once; a read re-arms the latch so the fall pulses too, on both channels
		reg_a = 8'h80;
		reg_b = 8'h80;
		pos_a <= 4'h0;
		pos_b <= 4'h0;
		negs <= 16'h0000;
		wr_reg(2'h0, reg_a);
		wr_reg(2'h1, reg_b);
		check_all;
		base = n_chg;
		pos_a <= 4'hF;
		pos_b <= 4'hF;
		repeat (10) @(posedge mclk_in);
		chk(8'(n_chg - base), 8'h11);
		rd_reg(2'h0, d);
		rd_reg(2'h1, d);
		pos_a <= 4'h0;
		pos_b <= 4'h0;
		repeat (10) @(posedge mclk_in);
		chk(8'(n_chg - base), 8'h22);
		pos_a <= 4'hF;
		pos_b <= 4'hF;
		repeat (10) @(posedge mclk_in);
		pos_a <= 4'h0;
		pos_b <= 4'h0;
		repeat (10) @(posedge mclk_in);
		chk(8'(n_chg - base), 8'h33);
		rand_cfg;
		reset_n_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		reset_n_in <= 1'b1;
		reg_a = 8'h00;
		reg_b = 8'h00;
		check_all;
		end_of_test;
	end
endmodule
